// >>> dscr_pkg.sv
package dscr_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_MUTE_DEEMPH = 8'h13;
  localparam logic [7:0] IDX_PATH_CFG = 8'h14;
  localparam logic [9:0] ADDR_MUTE_DEEMPH = {IDX_MUTE_DEEMPH, 2'h0};
  localparam logic [9:0] ADDR_PATH_CFG = {IDX_PATH_CFG, 2'h0};

  // Reset values.
  localparam logic [15:0] RST_MUTE_DEEMPH = 16'h0800;
  localparam logic [15:0] RST_PATH_CFG = 16'h4d00;

  // Fields of the mute and de-emphasis register.
  localparam int B_RSVD = 15;
  localparam int B_MASTER_QUIET = 14;
  localparam int B_GAIN_BOOST = 13;
  localparam int B_BLEND_GAIN = 12;
  localparam int B_CH2_QUIET = 11;
  localparam int F_CH2_DEEMPH_LO = 8;
  localparam int F_SHAPER_MODE_LO = 6;
  localparam int B_WCLK_SRC = 5;
  localparam int B_DEEMPH_SRC = 4;
  localparam int B_CH1_QUIET = 3;
  localparam int F_CH1_DEEMPH_LO = 0;

  // Fields of the path configuration register.
  localparam int B_POL_INV = 15;
  localparam int B_SHAPER_ORDER = 14;
  localparam int B_MIX_POS = 13;
  localparam int B_MIX_EN = 12;
  localparam int F_CH2_IN_LO = 10;
  localparam int F_CH1_IN_LO = 8;
  localparam int B_SIL_OVERRULE = 7;
  localparam int B_QDET_EN = 6;
  localparam int F_QCOUNT_LO = 4;
  localparam int B_BASS_SEL = 3;
  localparam int B_BYPASS = 2;
  localparam int F_OVERSAMPLE_INPUT_SEL_LO = 0;

  // AHB transfer type and size codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : dscr_pkg

// >>> dscr_dac_sound_regs.sv
`timescale 1ns/100ps
module dscr_dac_sound_regs
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Status from the audio path.
  input wire logic wordClockEdgeDetector,
  input wire logic fractionalLockLoop,
  input wire logic streamPreEmphasis,
  // Mute and de-emphasis controls.
  output logic masterQuiet,
  output logic ch1Quiet,
  output logic ch2Quiet,
  output logic shaperQuiet,
  output logic wordClockPresent,
  output logic [2:0] ch1DeemphFilter,
  output logic [2:0] ch2DeemphFilter,
  output logic useStreamDeemph,
  // Gain decisions.
  output logic dacGain6dB,
  output logic mixGainMinus6dB,
  // Path configuration.
  output logic outputPolarityInvert,
  output logic shaperOrderSel,
  output logic mixAfterProcessing,
  output logic mixEnable,
  output logic [1:0] interpCh2InputSel,
  output logic [1:0] interpCh1InputSel,
  output logic silenceOverrule,
  output logic quietDetectorEnable,
  output logic [1:0] quietSampleCount,
  output logic resonantBassSel,
  output logic normalBassEnable,
  output logic interpBypass,
  output logic [1:0] oversampleInputSel
);

  logic [15:0] muteReg_r;
  logic [15:0] muteReg_nxt;
  logic [15:0] pathReg_r;
  logic [15:0] pathReg_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic wrPend_r;
  logic [9:0] wrAddr_r;

  // Address phase decode; only whole-word writes reach the registers.
  wire logic addrPhase;
  wire logic isWord;
  wire logic [9:0] byteAddr;
  wire logic hitMute;
  wire logic hitPath;
  wire logic takeWrite;
  wire logic takeRead;
  assign addrPhase = hsel && hready && (htrans == dscr_pkg::HTRANS_NONSEQ ||
                     htrans == dscr_pkg::HTRANS_SEQ);
  assign isWord = (hsize == dscr_pkg::HSIZE_WORD);
  assign byteAddr = haddr[9:0];
  assign hitMute = (byteAddr == dscr_pkg::ADDR_MUTE_DEEMPH) &&
                   (haddr[31:10] == 22'h000000);
  assign hitPath = (byteAddr == dscr_pkg::ADDR_PATH_CFG) &&
                   (haddr[31:10] == 22'h000000);
  // Writes outside the two registers must never land, so the full decode
  // gates the pending write rather than the stored low address bits alone.
  assign takeWrite = addrPhase && hwrite && isWord && (hitMute || hitPath);
  assign takeRead = addrPhase && !hwrite;

  // Data phase write; the reserved bit is forced to zero on every store.
  wire logic wrMute;
  wire logic wrPath;
  assign wrMute = wrPend_r && (wrAddr_r == dscr_pkg::ADDR_MUTE_DEEMPH);
  assign wrPath = wrPend_r && (wrAddr_r == dscr_pkg::ADDR_PATH_CFG);
  assign muteReg_nxt = wrMute ? {1'b0, hwdata[14:0]} : muteReg_r;
  assign pathReg_nxt = wrPath ? hwdata[15:0] : pathReg_r;

  // Read data is latched at the address phase so the slave never waits.
  // A read that lands the cycle after a write to the same register would
  // see the old value, so the pending write is forwarded.
  wire logic [15:0] muteView;
  wire logic [15:0] pathView;
  assign muteView = wrMute ? muteReg_nxt : muteReg_r;
  assign pathView = wrPath ? pathReg_nxt : pathReg_r;
  assign hrdata_nxt = !takeRead ? 32'h00000000 :
                      hitMute ? {16'h0000, muteView} :
                      hitPath ? {16'h0000, pathView} : 32'h00000000;

  // Registers and bus state.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      muteReg_r <= dscr_pkg::RST_MUTE_DEEMPH;
      pathReg_r <= dscr_pkg::RST_PATH_CFG;
      hrdata_r <= 32'h00000000;
      wrPend_r <= 1'b0;
      wrAddr_r <= 10'h000;
    end
    else
    begin
      muteReg_r <= muteReg_nxt;
      pathReg_r <= pathReg_nxt;
      hrdata_r <= hrdata_nxt;
      wrPend_r <= takeWrite;
      wrAddr_r <= byteAddr;
    end
  end

  // Zero wait states and always OKAY; unmapped reads return zero.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Mute controls; the ramp itself lives in the audio path.
  assign masterQuiet = muteReg_r[dscr_pkg::B_MASTER_QUIET];
  assign ch2Quiet = muteReg_r[dscr_pkg::B_CH2_QUIET];
  assign ch1Quiet = muteReg_r[dscr_pkg::B_CH1_QUIET];

  // Word clock presence comes from the selected detector.
  assign wordClockPresent = muteReg_r[dscr_pkg::B_WCLK_SRC] ?
                            fractionalLockLoop :
                            wordClockEdgeDetector;

  // Noise shaper mute mode.
  wire logic [1:0] shaperMode;
  assign shaperMode = muteReg_r[dscr_pkg::F_SHAPER_MODE_LO +: 2];
  assign shaperQuiet = shaperMode[1] ||
                       (shaperMode[0] && !wordClockPresent);

  // De-emphasis: the stream's pre-emphasis flag maps to the 44.1 kHz filter
  // as a neutral default, since the stream carries no rate of its own here.
  wire logic deemphProgrammed;
  wire logic [2:0] streamFilter;
  assign deemphProgrammed = muteReg_r[dscr_pkg::B_DEEMPH_SRC];
  assign useStreamDeemph = !deemphProgrammed;
  assign streamFilter = streamPreEmphasis ? 3'h2 : 3'h0;
  assign ch2DeemphFilter = deemphProgrammed ?
                           muteReg_r[dscr_pkg::F_CH2_DEEMPH_LO +: 3] :
                           streamFilter;
  assign ch1DeemphFilter = deemphProgrammed ?
                           muteReg_r[dscr_pkg::F_CH1_DEEMPH_LO +: 3] :
                           streamFilter;

  // Gain decisions from boost select, mixer enable and blend gain.
  wire logic gainBoost;
  wire logic blendGain;
  assign gainBoost = muteReg_r[dscr_pkg::B_GAIN_BOOST];
  assign blendGain = muteReg_r[dscr_pkg::B_BLEND_GAIN];
  assign mixEnable = pathReg_r[dscr_pkg::B_MIX_EN];
  assign dacGain6dB = gainBoost && !(mixEnable && !blendGain);
  assign mixGainMinus6dB = mixEnable && !blendGain;

  // Path configuration fields.
  assign outputPolarityInvert = pathReg_r[dscr_pkg::B_POL_INV];
  assign shaperOrderSel = pathReg_r[dscr_pkg::B_SHAPER_ORDER];
  assign mixAfterProcessing = pathReg_r[dscr_pkg::B_MIX_POS];
  assign interpCh2InputSel = pathReg_r[dscr_pkg::F_CH2_IN_LO +: 2];
  assign interpCh1InputSel = pathReg_r[dscr_pkg::F_CH1_IN_LO +: 2];
  assign silenceOverrule = pathReg_r[dscr_pkg::B_SIL_OVERRULE];
  assign quietDetectorEnable = pathReg_r[dscr_pkg::B_QDET_EN];
  assign quietSampleCount = pathReg_r[dscr_pkg::F_QCOUNT_LO +: 2];
  assign interpBypass = pathReg_r[dscr_pkg::B_BYPASS];
  assign oversampleInputSel = pathReg_r[dscr_pkg::F_OVERSAMPLE_INPUT_SEL_LO +: 2];

  // Bass boost selection; normal settings are gated off in resonant mode.
  assign resonantBassSel = pathReg_r[dscr_pkg::B_BASS_SEL];
  assign normalBassEnable = !resonantBassSel;

endmodule : dscr_dac_sound_regs

// >>> dscr_dac_sound_regs_monitor.sv
`timescale 1ns/100ps
module dscr_dac_sound_regs_monitor
(
  // Clock and reset.
  input wire logic sys_clk, nrst,
  // Bus side.
  input wire logic hsel, hready, hwrite,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // Audio status and controls.
  input wire logic wordClockEdgeDetector, fractionalLockLoop,
  input wire logic streamPreEmphasis, useStreamDeemph, wordClockPresent,
  input wire logic masterQuiet, ch1Quiet, ch2Quiet, dacGain6dB,
  input wire logic mixGainMinus6dB, mixEnable, resonantBassSel,
  input wire logic normalBassEnable, outputPolarityInvert, shaperOrderSel,
  input wire logic [2:0] ch1DeemphFilter, ch2DeemphFilter
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // A word access is taken here; narrow writes never reach the registers.
  wire take = hsel && hready && htrans[1] && hsize == 3'h2;
  // Address phase followed by its one-cycle data phase.
  sequence s_wr_mute;
    take && hwrite && haddr == 32'h4c ##1 1'b1;
  endsequence
  sequence s_rd(logic [31:0] a);
    take && !hwrite && haddr == a ##1 1'b1;
  endsequence
  AST_WRMUTE: assert property (s_wr_mute |=>
    {masterQuiet, ch2Quiet, ch1Quiet} ==
    {$past(hwdata[14]), $past(hwdata[11]), $past(hwdata[3])})
    else $error("mute bits do not follow the written word");
  AST_RDMUTE: assert property (s_rd(32'h4c) |->
    hrdata[31:14] == {17'h0, masterQuiet} && hrdata[11] == ch2Quiet)
    else $error("mute register read data is wrong");
  AST_RDPATH: assert property (s_rd(32'h50) |->
    hrdata[31:14] == {16'h0, outputPolarityInvert, shaperOrderSel} &&
    hrdata[12] == mixEnable && hrdata[3] == resonantBassSel)
    else $error("path register read data is wrong");
  AST_GAIN: assert property (mixGainMinus6dB |->
    mixEnable && !dacGain6dB) else $error("mixer gain without mixer");
  AST_BASS: assert property (normalBassEnable != resonantBassSel)
    else $error("normal bass enable not inverse of bass select");
  AST_WCLK: assert property (wordClockEdgeDetector ==
    fractionalLockLoop |-> wordClockPresent == fractionalLockLoop)
    else $error("word clock presence from neither source");
  AST_STREAM: assert property (useStreamDeemph |->
    {ch2DeemphFilter, ch1DeemphFilter} == (streamPreEmphasis ? 6'h12 : 6'h0))
    else $error("stream de-emphasis not followed");
  AST_RST: assert property ($rose(nrst) |->
    {masterQuiet, ch2Quiet, ch1Quiet} == 3'h2)
    else $error("mute bits wrong after reset");
endmodule : dscr_dac_sound_regs_monitor

// >>> dac_sound_control_regs_test.sv
`timescale 1ns/100ps
module dac_sound_control_regs_test;
  logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic wordClockEdgeDetector = 1'b0, fractionalLockLoop = 1'b0;
  logic streamPreEmphasis = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp, masterQuiet, ch1Quiet, ch2Quiet, shaperQuiet;
  logic wordClockPresent, useStreamDeemph, dacGain6dB, mixGainMinus6dB;
  logic mixEnable, normalBassEnable, resonantBassSel;
  logic outputPolarityInvert, shaperOrderSel;
  logic [2:0] ch1DeemphFilter, ch2DeemphFilter;
  logic [31:0] qm [3] = '{32'h4000, 32'h800, 32'h8};
  int errCount = 0, checked = 0, cyc = 0;
  // The single slave's ready is the bus ready.
  dscr_dac_sound_regs dut_u (.hreadyout(hready), .mixAfterProcessing(),
    .interpCh2InputSel(), .interpCh1InputSel(), .silenceOverrule(),
    .quietDetectorEnable(), .quietSampleCount(), .interpBypass(),
    .oversampleInputSel(), .*);
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // One single word transfer; ends off the edge so outputs have settled.
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= dscr_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    @(negedge sys_clk);
  endtask : xfer
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test;
    if (errCount == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // A hang is cut well beyond the under two hundred cycles the run needs.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errCount++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    xfer(1'b0, 32'h4c, 32'h0);
    chk("muteReg", 32'h800, rd);
    xfer(1'b0, 32'h50, 32'h0);
    chk("pathReg", 32'h4d00, rd);
    xfer(1'b1, 32'h4c, 32'hffff_ffff);
    xfer(1'b0, 32'h4c, 32'h0);
    chk("muteReg", 32'h7fff, rd);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, 32'h4c, qm[i]);
      chk("quiet", 32'h4 >> i, {masterQuiet, ch2Quiet, ch1Quiet});
    end
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, 32'h4c, 32'h10 | 32'(i << 8) | 32'(4 - i));
      chk("deemph", 32'(i * 8 + 4 - i),
        {ch2DeemphFilter, ch1DeemphFilter});
    end
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      streamPreEmphasis <= i[0];
      xfer(1'b1, 32'h4c, 32'h707);
      chk("stream", i * 18, {ch2DeemphFilter, ch1DeemphFilter});
      chk("deemphSrc", 32'h1, useStreamDeemph);
    end
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sys_clk);
      wordClockEdgeDetector <= i[0];
      fractionalLockLoop <= !i[0];
      xfer(1'b1, 32'h4c, 32'(i[3:1]) << 5);
      chk("shaper", {i[3] | (i[3:2] == 2'h1 && !(i[1] ^ i[0])),
        i[1] ^ i[0]}, {shaperQuiet, wordClockPresent});
    end
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 32'h50, {19'h0, i[0], 12'h0});
      xfer(1'b1, 32'h4c, {18'h0, i[2:1], 12'h0});
      chk("gain", {i[0], i[2] & !(i[0] & !i[1]), i[0] & !i[1]},
        {mixEnable, dacGain6dB, mixGainMinus6dB});
    end
    xfer(1'b1, 32'h50, 32'hffff_0008);
    xfer(1'b0, 32'h50, 32'h0);
    chk("pathReg", 32'h8, rd);
    chk("bass", 32'h1, {normalBassEnable, resonantBassSel});
    xfer(1'b1, 32'h54, 32'hffff);
    xfer(1'b0, 32'h54, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b1, 32'h1000_004c, 32'h4000);
    chk("farAlias", 32'h0, masterQuiet);
    chk("hresp", 32'h0, hresp);
    stop_test();
  end
endmodule : dac_sound_control_regs_test
// The checker watches the design's own ports by name.
bind dscr_dac_sound_regs dscr_dac_sound_regs_monitor mon_u (.*);
